// ===== logic/pcs_ctrl.sv
// pcs_ctrl: phy control states for transmitter-off and quiet-after-restart
// assumes: management reset, role and receiver status come from outside the clock domain
`timescale 1ns/10ps

// What this block does
// - In transmitter-off state the line transmitter stays disabled.
// - A management reset request forces transmitter-off, disabling transmit on entry.
// - Leader or follower role is selectable; transmitter-off behaves the same.
// - In the quiet state nothing is sent, in either role.
// - A leader leaves quiet at once, without waiting for lock or receiver.
// - A follower stays quiet until a valid idle pattern is received.
// - Once partner idle is valid, the device sends its own idle.
// - Invalid symbols after link up return to quiet, and training restarts from there.
module pcs_ctrl
	import pcs_pkg::*;
(
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_b,
	// management
	input  wire logic         pma_reset_req,
	input  wire logic         leader_sel,
	// receiver status
	input  wire pcs_rx_stat_t rx_stat,
	// transmit control
	output logic              tx_enable,
	output pcs_tx_mode_t      tx_mode,
	// state visibility
	output pcs_state_t        ctrl_state,
	output logic              link_up
);

	// ------------------------------------------------------------
	// input synchronisation
	// ------------------------------------------------------------
	localparam int NSYNC = PCS_NSYNC;

	logic [NSYNC-1:0] raw_in;
	logic [NSYNC-1:0] sync_in;
	logic             rst_req;
	logic             leader;
	pcs_rx_stat_t     rx;

	assign raw_in = {pma_reset_req, leader_sel, rx_stat};

	pcs_sync #(
		.W       (NSYNC),
		.RST_VAL (PCS_SYNC_RST)
	) u_sync (
		.mclk  (mclk),
		.rst_b (rst_b),
		.din   (raw_in),
		.dout  (sync_in)
	);

	// request lane resets high: a held request keeps tx off across reset release
	assign rst_req = sync_in[PCS_REQ_BIT];
	assign leader  = sync_in[PCS_LEAD_BIT];
	assign rx      = pcs_rx_stat_t'(sync_in[$bits(pcs_rx_stat_t)-1:0]);

	// ------------------------------------------------------------
	// state machine
	// ------------------------------------------------------------
	pcs_state_t   state_q;
	pcs_state_t   state_d;
	pcs_tx_mode_t mode_q;
	pcs_tx_mode_t mode_d;
	logic         txen_q;
	logic         txen_d;
	logic         link_q;
	logic         link_d;

	always_comb
	begin
		state_d = state_q;
		if (rst_req)
		begin
			state_d = PCS_TX_OFF;
		end
		else
		begin
			case (state_q)
				PCS_TX_OFF:
				begin
					state_d = PCS_QUIET;
				end
				PCS_QUIET:
				begin
					if (leader)
					begin
						state_d = PCS_TRAIN;
					end
					else if (rx.idle_ok)
					begin
						state_d = PCS_TRAIN;
					end
				end
				PCS_TRAIN:
				begin
					if (rx.loc_ok && rx.rem_ok)
					begin
						state_d = PCS_LINKED;
					end
				end
				PCS_LINKED:
				begin
					if (rx.bad_sym)
					begin
						state_d = PCS_QUIET;
					end
				end
				default:
				begin
					state_d = PCS_TX_OFF;
				end
			endcase
		end
	end

	// outputs follow the next state so they line up with it
	always_comb
	begin
		mode_d = PCS_SEND_Z;
		txen_d = 1'b0;
		link_d = 1'b0;
		case (state_d)
			PCS_TX_OFF:
			begin
				txen_d = 1'b0;
				mode_d = PCS_SEND_Z;
			end
			PCS_QUIET:
			begin
				txen_d = 1'b1;
				mode_d = PCS_SEND_Z;
			end
			PCS_TRAIN:
			begin
				txen_d = 1'b1;
				mode_d = PCS_SEND_I;
			end
			PCS_LINKED:
			begin
				txen_d = 1'b1;
				mode_d = PCS_SEND_N;
				link_d = 1'b1;
			end
			default:
			begin
				txen_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			state_q <= PCS_TX_OFF;
			mode_q  <= PCS_SEND_Z;
			txen_q  <= 1'b0;
			link_q  <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			mode_q  <= mode_d;
			txen_q  <= txen_d;
			link_q  <= link_d;
		end
	end

	assign tx_enable  = txen_q;
	assign tx_mode    = mode_q;
	assign ctrl_state = state_q;
	assign link_up    = link_q;

endmodule // pcs_ctrl

// ===== logic/pcs_pkg.sv
// pcs_pkg: shared types and constants for the phy control reset/silent block
// assumes: one 100 MHz clock, synchronous active-low reset
package pcs_pkg;

	// ------------------------------------------------------------
	// states, one-hot
	// ------------------------------------------------------------
	typedef enum logic [3:0]
	{
		PCS_TX_OFF = 4'h1,
		PCS_QUIET  = 4'h2,
		PCS_TRAIN  = 4'h4,
		PCS_LINKED = 4'h8
	} pcs_state_t;

	// ------------------------------------------------------------
	// transmit modes
	// ------------------------------------------------------------
	typedef enum logic [1:0]
	{
		PCS_SEND_Z = 2'h0,
		PCS_SEND_I = 2'h1,
		PCS_SEND_N = 2'h2
	} pcs_tx_mode_t;

	// ------------------------------------------------------------
	// receiver status bundle from the outside
	// ------------------------------------------------------------
	typedef struct packed
	{
		logic idle_ok;
		logic bad_sym;
		logic loc_ok;
		logic rem_ok;
	} pcs_rx_stat_t;

	localparam logic [1:0] PCS_SYNC_STAGES = 2'h2;

	// ------------------------------------------------------------
	// synchroniser lanes: reset request, role, receiver status
	// ------------------------------------------------------------
	localparam int         PCS_NSYNC    = 6;
	localparam int         PCS_REQ_BIT  = 5;
	localparam int         PCS_LEAD_BIT = 4;
	// reset request reads as held until the pins have been sampled
	localparam logic [5:0] PCS_SYNC_RST = 6'h20;

endpackage : pcs_pkg

// ===== logic/pcs_sync.sv
// pcs_sync: two-flop synchroniser for a vector of levels
// assumes: inputs are asynchronous to mclk
`timescale 1ns/10ps
module pcs_sync
	import pcs_pkg::*;
#(
	parameter int           W       = 1,
	parameter logic [W-1:0] RST_VAL = '0
)
(
	// clock and reset
	input  wire logic         mclk,
	input  wire logic         rst_b,
	// data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	logic [W-1:0] meta_q;
	logic [W-1:0] meta_d;
	logic [W-1:0] sync_q;
	logic [W-1:0] sync_d;

	always_comb
	begin
		meta_d = din;
		sync_d = meta_q;
	end

	always_ff @(posedge mclk)
	begin
		if (!rst_b)
		begin
			// per-lane reset level, so no lane shows a false level on release
			meta_q <= RST_VAL;
			sync_q <= RST_VAL;
		end
		else
		begin
			meta_q <= meta_d;
			sync_q <= sync_d;
		end
	end

	assign dout = sync_q;

endmodule // pcs_sync

// ===== sim/pcs_ctrl_asserts.sv
// pcs_ctrl_chk: port checks for pcs_ctrl
// assumes: bound to every pcs_ctrl
`timescale 1ns/10ps
module pcs_ctrl_chk
	import pcs_pkg::*;
(
	// watched ports
	input wire logic         mclk,
	input wire logic         rst_b,
	input wire logic         pma_reset_req,
	input wire logic         leader_sel,
	input wire pcs_rx_stat_t rx_stat,
	input wire logic         tx_enable,
	input wire pcs_tx_mode_t tx_mode,
	input wire pcs_state_t   ctrl_state,
	input wire logic         link_up
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_b);
	off_dis_a: assert property (ctrl_state == PCS_TX_OFF |-> !tx_enable)
		else $error("tx on in off");
	req_off_a: assert property (pma_reset_req [*4] |-> ctrl_state == PCS_TX_OFF)
		else $error("req ignored");
	quiet_mute_a: assert property (ctrl_state == PCS_QUIET |-> tx_mode == PCS_SEND_Z)
		else $error("quiet sends");
	lead_go_a: assert property (leader_sel [*4] ##0 ctrl_state == PCS_QUIET
		|=> ctrl_state != PCS_QUIET) else $error("leader stuck");
	follow_hold_a: assert property ((!leader_sel && !rx_stat.idle_ok) [*4] ##0
		ctrl_state == PCS_QUIET |=> ctrl_state != PCS_TRAIN) else $error("follower left");
	train_idle_a: assert property (ctrl_state == PCS_TRAIN
		|-> tx_enable && tx_mode == PCS_SEND_I) else $error("train not idle");
	bad_restart_a: assert property (link_up && rx_stat.bad_sym |-> ##[1:4] !link_up)
		else $error("no restart");
	off_exit_a: assert property ($fell(ctrl_state == PCS_TX_OFF)
		|-> ctrl_state == PCS_QUIET) else $error("off exit skips quiet");
endmodule // pcs_ctrl_chk
bind pcs_ctrl pcs_ctrl_chk i_pcs_ctrl_chk (.mclk(mclk), .rst_b(rst_b),
	.pma_reset_req(pma_reset_req), .leader_sel(leader_sel), .rx_stat(rx_stat),
	.tx_enable(tx_enable), .tx_mode(tx_mode), .ctrl_state(ctrl_state), .link_up(link_up));

// ===== sim/pcs_peer.sv
// pcs_peer: link partner as seen through receiver status
// assumes: bench picks what the partner sends
`timescale 1ns/10ps
module pcs_peer
	import pcs_pkg::*;
(
	// partner activity
	input  wire logic    idle,
	input  wire logic    bad,
	input  wire logic    lock,
	// receiver status
	output pcs_rx_stat_t rx_stat
);
	assign rx_stat = {idle, bad, lock, lock};
endmodule // pcs_peer

// ===== sim/pcs_ctrl_tb_top.sv
// pcs_ctrl_tb_top: reset and restart walk in both roles
// assumes: pcs_ctrl, pcs_peer and the checker compiled first
`timescale 1ns/10ps
module pcs_ctrl_tb_top
	import pcs_pkg::*;
;
	logic         mclk = 0, rst_b = 0, req = 1, lead = 0, idle = 0, bad = 0, lock = 0;
	logic         en, up, first;
	int           ms = 1;
	logic [5:0]   mq[$] = '{6'h20, 6'h20};
	logic [5:0]   mv;
	int           errors = 0, checks = 0;
	pcs_rx_stat_t rx_stat;
	pcs_tx_mode_t mode;
	pcs_state_t   st;
	always #5 mclk = ~mclk;
	pcs_peer i_pcs_peer (.idle(idle), .bad(bad), .lock(lock), .rx_stat(rx_stat));
	pcs_ctrl i_pcs_ctrl (.mclk(mclk), .rst_b(rst_b), .pma_reset_req(req), .leader_sel(lead),
		.rx_stat(rx_stat), .tx_enable(en), .tx_mode(mode), .ctrl_state(st), .link_up(up));
	// model: inputs reach the state two edges late, then the state rules apply
	always @(posedge mclk)
	begin
		if (!rst_b)
		begin
			ms = 1;
			mq = '{6'h20, 6'h20};
		end
		else
		begin
			mv = mq.pop_front();
			mq.push_back({req, lead, rx_stat});
			if (mv[5])
				ms = 1;
			else if (ms == 1)
				ms = 2;
			else if (ms == 2 && (mv[4] || mv[3]))
				ms = 4;
			else if (ms == 4 && mv[1] && mv[0])
				ms = 8;
			else if (ms == 8 && mv[2])
				ms = 2;
		end
		#2;
		checks++;
		if ({st, en, mode, up} !== {4'(ms), ms != 1, 2'(ms / 4), ms == 8})
		begin
			errors++;
			$display("CHECK FAILED outputs exp %h seen %h",
				{4'(ms), ms != 1, 2'(ms / 4), ms == 8}, {st, en, mode, up});
		end
	end
	task stop_test;
		$display("checks %0d errors %0d", checks, errors);
		if (errors == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input pcs_state_t e);
		repeat (6) @(posedge mclk);
		#1;
		checks++;
		if ({st, en} !== {e, e != PCS_TX_OFF})
		begin
			errors++;
			$display("CHECK FAILED state exp %h seen %h", e, st);
		end
	endtask
	initial
	begin
		void'($urandom(32'hC975));
		first = 1'($urandom);
		repeat (2) @(posedge mclk);
		#1 rst_b = 1;
		for (int i = 0; i < 2; i++)
		begin
			lead = first ^ 1'(i);
			{req, idle, bad, lock} = 4'h8;
			chk(PCS_TX_OFF);
			req = 0;
			chk(lead ? PCS_TRAIN : PCS_QUIET);
			idle = 1;
			chk(PCS_TRAIN);
			lock = 1;
			chk(PCS_LINKED);
			{idle, bad, lock} = 3'h2;
			chk(lead ? PCS_TRAIN : PCS_QUIET);
		end
		rst_b = 0;
		repeat (2) @(posedge mclk);
		#1 rst_b = 1;
		chk(lead ? PCS_TRAIN : PCS_QUIET);
		stop_test;
	end
	initial
	begin
		#2000;
		errors++;
		stop_test;
	end
endmodule // pcs_ctrl_tb_top
